// file: include/ccpos_pkg.sv
`default_nettype none
package ccpos_pkg;
  // =====================================
  // register map
  localparam logic [3:0] CCPOS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CCPOS_ADDR_STAT = 4'h1;
  localparam logic [15:0] CCPOS_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CCPOS_CTRL_WMASK = 16'hf73f;
  localparam int CCPOS_HOLD_BIT = 15;
  localparam int CCPOS_CNT_LSB = 12;
  localparam int CCPOS_RSV_BIT = 11;
  localparam int CCPOS_MODE_LSB = 8;
  localparam int CCPOS_POL1_BIT = 5;
  localparam int CCPOS_POL2_BIT = 4;
  localparam int CCPOS_FIELD_W = 3;
  // =====================================
  // output pin modes
  localparam logic [2:0] CCPOS_MODE_SINGLE = 3'h0;
  localparam logic [2:0] CCPOS_MODE_PUSHPULL = 3'h1;
  localparam logic [2:0] CCPOS_MODE_HALFBR = 3'h2;
  localparam logic [2:0] CCPOS_MODE_RSV3 = 3'h3;
  localparam logic [2:0] CCPOS_MODE_BDC_REV = 3'h4;
  localparam logic [2:0] CCPOS_MODE_BDC_FWD = 3'h5;
  localparam logic [2:0] CCPOS_MODE_SCAN = 3'h6;
  localparam logic [2:0] CCPOS_MODE_RSV7 = 3'h7;
  localparam int CCPOS_NUM_PINS = 6;
endpackage : ccpos_pkg
`default_nettype wire

// file: logic/ccpos_stretch.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================
// one-shot stretcher: holds a one-period pulse for count+1 periods
module ccpos_stretch
  import ccpos_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tb_tick,
  input wire logic shot_in,
  input wire logic [2:0] ext_count,
  output logic shot_out
);
  logic [2:0] left_q;
  logic busy_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_q <= 3'h0;
      busy_q <= 1'b0;
    end
    else if (shot_in)
    begin
      left_q <= ext_count;
      busy_q <= 1'b1;
    end
    else if (tb_tick && busy_q)
    begin
      if (left_q == 3'h0)
        busy_q <= 1'b0;
      else
        left_q <= left_q - 3'h1;
    end
  end

  assign shot_out = busy_q;

  zero_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_q && left_q == 3'h0 && tb_tick && !shot_in) |=> !busy_q)
    else $error("zero count one-shot not ended after one period");
  load_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    shot_in |=> (busy_q && left_q == $past(ext_count)))
    else $error("one-shot extension count not loaded");
  hold_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    (busy_q && left_q != 3'h0 && !shot_in) |=> busy_q)
    else $error("one-shot ended before its count ran out");
endmodule : ccpos_stretch
`default_nettype wire

// file: logic/ccpos_top.sv
// Contract
// - hold outputs off until trigger when enabled
// - count N stretches one-shot N periods
// - count zero gives no extension
// - bit 11 reads zero, ignores writes
// - codes 110,101,100 scan, brush fwd, rev
// - codes 010,001,000 half, push-pull, single
// - group one polarity bit makes A,C,E low
// - group two polarity bit makes B,D,F low
// - cleared polarity bit means active high
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ccpos_top
  import ccpos_pkg::*;
#(
  parameter int PINS_BDF = 1
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic tb_tick,
  input wire logic triggered_operation_enable,
  input wire logic trigger_in,
  input wire logic one_shot_in,
  input wire logic pwm_primary,
  input wire logic pwm_secondary,
  input wire logic [1:0] scan_select,
  output logic output_pin_a,
  output logic output_pin_b,
  output logic output_pin_c,
  output logic output_pin_d,
  output logic output_pin_e,
  output logic output_pin_f,
  output logic [5:0] output_pin_oe_b,
  output logic one_shot_active
);
  // only the full six-pin stage or the a, c, e subset is served
  if (PINS_BDF != 0 && PINS_BDF != 1)
  begin : g_bad_pins_bdf
    $error("PINS_BDF must be 0 or 1");
  end

  // =====================================
  // control register
  logic [15:0] ctrl_q;
  logic hold_outputs_until_trigger;
  logic [2:0] one_shot_extension_count;
  logic [2:0] output_pin_mode_select;
  logic polarity_group_one;
  logic polarity_group_two;
  logic [15:0] wmask;

  // bdf polarity only exists where pins b, d, f exist
  assign wmask = (PINS_BDF == 1) ? CCPOS_CTRL_WMASK
               : (CCPOS_CTRL_WMASK & ~(16'h0001 << CCPOS_POL2_BIT));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= CCPOS_CTRL_RESET;
    else if (reg_wr && reg_addr == CCPOS_ADDR_CTRL)
      ctrl_q <= reg_wdata & wmask;
  end

  assign hold_outputs_until_trigger = ctrl_q[CCPOS_HOLD_BIT];
  assign one_shot_extension_count = ctrl_q[CCPOS_CNT_LSB +: CCPOS_FIELD_W];
  assign output_pin_mode_select = ctrl_q[CCPOS_MODE_LSB +: CCPOS_FIELD_W];
  assign polarity_group_one = ctrl_q[CCPOS_POL1_BIT];
  assign polarity_group_two = ctrl_q[CCPOS_POL2_BIT];

  // =====================================
  // trigger gating
  logic held_q;
  logic hold_cond;
  assign hold_cond = triggered_operation_enable && hold_outputs_until_trigger;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      held_q <= 1'b1;
    else if (!hold_cond)
      held_q <= 1'b1;
    else if (trigger_in)
      held_q <= 1'b0;
  end

  logic gated;
  assign gated = hold_cond && held_q;

  // =====================================
  // one-shot stretch
  logic shot;
  ccpos_stretch u_stretch (
    .clk(clk),
    .rst_b(rst_b),
    .tb_tick(tb_tick),
    .shot_in(one_shot_in),
    .ext_count(one_shot_extension_count),
    .shot_out(shot)
  );
  assign one_shot_active = shot;

  // =====================================
  // mode steering, active-high levels of a..f
  logic [5:0] lvl;
  logic [5:0] en;
  always_comb
  begin
    lvl = 6'h00;
    en = 6'h00;
    unique case (output_pin_mode_select)
      CCPOS_MODE_SINGLE:
      begin
        lvl = 6'h01 & {6{pwm_primary}};
        en = 6'h01;
      end
      CCPOS_MODE_PUSHPULL:
      begin
        lvl = {4'h0, pwm_secondary, pwm_primary};
        en = 6'h03;
      end
      CCPOS_MODE_HALFBR:
      begin
        lvl = {4'h0, ~pwm_primary, pwm_primary};
        en = 6'h03;
      end
      CCPOS_MODE_BDC_REV:
      begin
        lvl = {4'h0, pwm_primary, 1'b0};
        en = 6'h0f;
        lvl[2] = 1'b1;
      end
      CCPOS_MODE_BDC_FWD:
      begin
        lvl = {2'h0, 1'b1, 2'h0, pwm_primary};
        en = 6'h0f;
      end
      // output scan, one pin at a time
      CCPOS_MODE_SCAN:
      begin
        lvl = {2'h0, pwm_primary & (scan_select == 2'h3),
               pwm_primary & (scan_select == 2'h2),
               pwm_primary & (scan_select == 2'h1),
               pwm_primary & (scan_select == 2'h0)};
        en = 6'h0f;
      end
      // reserved codes leave every pin undriven
      CCPOS_MODE_RSV3, CCPOS_MODE_RSV7:
      begin
        lvl = 6'h00;
        en = 6'h00;
      end
    endcase
  end

  // one-shot holds pin a asserted while stretched, unless the mode leaves a disabled
  logic [5:0] act;
  logic [5:0] en_eff;
  assign act = lvl | {5'h00, shot & en[0]};
  assign en_eff = (PINS_BDF == 1) ? en : (en & 6'h15);

  // =====================================
  // polarity and output flops
  logic [5:0] pol;
  logic [5:0] pin_q;
  logic [5:0] oe_b_q;
  // group one inverts a, c, e
  // group two inverts b, d, f
  assign pol = {polarity_group_two, polarity_group_one, polarity_group_two,
                polarity_group_one, polarity_group_two, polarity_group_one};

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_q <= 6'h00;
    else
      pin_q <= act ^ pol;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oe_b_q <= 6'h3f;
    else
      oe_b_q <= gated ? 6'h3f : ~en_eff;
  end

  assign {output_pin_f, output_pin_e, output_pin_d,
          output_pin_c, output_pin_b, output_pin_a} = pin_q;
  assign output_pin_oe_b = oe_b_q;

  // =====================================
  // register read
  logic [15:0] rdata_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= 16'h0000;
    else if (reg_rd && reg_addr == CCPOS_ADDR_CTRL)
      rdata_q <= ctrl_q & ~(16'h0001 << CCPOS_RSV_BIT);
    else if (reg_rd && reg_addr == CCPOS_ADDR_STAT)
      rdata_q <= {13'h0000, shot, gated, held_q};
    else
      rdata_q <= 16'h0000;
  end
  assign reg_rdata = rdata_q;

  // =====================================
  // checks
  sequence gate_on_s;
    hold_cond && held_q;
  endsequence
  sequence trig_s;
    hold_cond && trigger_in;
  endsequence

  hold_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    gate_on_s |=> (output_pin_oe_b == 6'h3f))
    else $error("pins driven while held for trigger");
  trig_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    trig_s ##1 hold_cond |-> !held_q)
    else $error("trigger did not release hold");
  rsv_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd |=> !reg_rdata[CCPOS_RSV_BIT])
    else $error("reserved bit read nonzero");
  rsv_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl_q[CCPOS_RSV_BIT])
    else $error("reserved bit stored");
  pol_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(polarity_group_one) && !$past(act[0])) |-> output_pin_a)
    else $error("pin a not active low");
  pol_two_a: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(polarity_group_two) && !$past(act[1])) |-> output_pin_b)
    else $error("pin b not active low");
  pol_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!$past(polarity_group_one) && !$past(act[2])) |-> !output_pin_c)
    else $error("pin c not active high");
  pol_high_two_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!$past(polarity_group_two) && !$past(act[1])) |-> !output_pin_b)
    else $error("pin b not active high");
  scan_en_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_SCAN && !gated) |=>
      output_pin_oe_b[3:0] == ((PINS_BDF == 1) ? 4'h0 : 4'ha))
    else $error("scan mode pins not enabled");
  // brush modes enable a to d
  brush_en_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((output_pin_mode_select == CCPOS_MODE_BDC_FWD ||
      output_pin_mode_select == CCPOS_MODE_BDC_REV) && !gated) |=>
      output_pin_oe_b[3:0] == ((PINS_BDF == 1) ? 4'h0 : 4'ha))
    else $error("brush mode pins not enabled");
  brush_fwd_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_BDC_FWD) |=>
      (output_pin_d != $past(polarity_group_two)))
    else $error("forward mode pin d not active");
  brush_rev_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_BDC_REV) |=>
      (output_pin_c != $past(polarity_group_one)))
    else $error("reverse mode pin c not active");
  rsv_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_RSV3 ||
      output_pin_mode_select == CCPOS_MODE_RSV7) |=> output_pin_oe_b == 6'h3f)
    else $error("reserved mode drives a pin");
  single_en_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_SINGLE && !gated) |=>
      output_pin_oe_b == 6'h3e)
    else $error("single mode enable wrong");
  single_lvl_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_SINGLE && !shot) |=>
      (output_pin_a == ($past(pwm_primary) ^ $past(polarity_group_one))))
    else $error("single mode pin a wrong");
  pushpull_en_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_PUSHPULL && !gated) |=>
      output_pin_oe_b == ((PINS_BDF == 1) ? 6'h3c : 6'h3e))
    else $error("push-pull enable wrong");
  pushpull_lvl_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_PUSHPULL) |=>
      (output_pin_b == ($past(pwm_secondary) ^ $past(polarity_group_two))))
    else $error("push-pull pin b wrong");
  // half-bridge pair complementary
  // a stretched one-shot forces a asserted, so it is left out here
  halfbr_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    (output_pin_mode_select == CCPOS_MODE_HALFBR && !shot &&
      polarity_group_one == polarity_group_two) |=> (output_pin_a != output_pin_b))
    else $error("half-bridge pins not complementary");
endmodule : ccpos_top
`default_nettype wire

// file: test/ccpos_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================
// power stage: every pin has a pull-down, so a released pin reads low
module ccpos_stage_model
(
  input wire logic [5:0] pin,
  input wire logic [5:0] drv_oe_b,
  output logic [5:0] level
);
  assign level = ~drv_oe_b & pin;
endmodule : ccpos_stage_model
`default_nettype wire

// file: test/tb_ccpos_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ccpos_top;
  import ccpos_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, tb_tick, trig_en, trigger_in, one_shot_in;
  logic pwm_primary, pwm_secondary, one_shot_active;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0] scan_select;
  logic [5:0] pin, oe_b, level;
  int n_mismatch, cmp_count, ticks;
  // =====================================
  // design and power stage
  ccpos_top ccpos_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tb_tick(tb_tick), .triggered_operation_enable(trig_en), .trigger_in(trigger_in),
    .one_shot_in(one_shot_in), .pwm_primary(pwm_primary), .pwm_secondary(pwm_secondary),
    .scan_select(scan_select), .output_pin_a(pin[0]), .output_pin_b(pin[1]),
    .output_pin_c(pin[2]), .output_pin_d(pin[3]), .output_pin_e(pin[4]),
    .output_pin_f(pin[5]), .output_pin_oe_b(oe_b), .one_shot_active(one_shot_active));
  ccpos_stage_model ccpos_stage_model_i (.pin(pin), .drv_oe_b(oe_b), .level(level));
  // =====================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  // mode in bits 10:8, polarity pair in bits 5:4; pins settle within 3 edges
  task automatic mode_chk(input logic [2:0] m, input logic [1:0] pol, input int idx,
    input logic exp);
    wr(CCPOS_ADDR_CTRL, {5'h00, m, 2'h0, pol, 4'h0});
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, level[idx]}, {15'h0000, exp});
  endtask : mode_chk
  // counts time base ticks until the stretched one-shot ends
  task automatic shot(input logic [2:0] n);
    wr(CCPOS_ADDR_CTRL, {1'b0, n, 12'h000});
    @(posedge clk);
    one_shot_in <= 1'b1;
    @(posedge clk);
    one_shot_in <= 1'b0;
    ticks = 0;
    #1;
    while (one_shot_active === 1'b1 && ticks < 12)
    begin
      @(posedge clk);
      tb_tick <= 1'b1;
      @(posedge clk);
      tb_tick <= 1'b0;
      ticks++;
      @(posedge clk);
      #1;
      chk({15'h0000, level[0]}, {15'h0000, (ticks <= n)});
    end
    chk(16'(ticks), {13'h0000, n} + 16'h0001);
  endtask : shot
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // =====================================
  // clock, watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  // =====================================
  // tests
  initial
  begin
    {rst_b, reg_wr, reg_rd, tb_tick, trig_en, trigger_in, one_shot_in} = 7'h00;
    {pwm_primary, pwm_secondary} = 2'h3;
    scan_select = 2'h2;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(CCPOS_ADDR_CTRL);
    chk(rd_val, CCPOS_CTRL_RESET);
    wr(CCPOS_ADDR_CTRL, 16'hffff);
    rd(CCPOS_ADDR_CTRL);
    chk(rd_val, 16'hf73f);
    wr(4'h9, 16'h0000);
    rd(4'hf);
    chk(rd_val, 16'h0000);
    rd(CCPOS_ADDR_CTRL);
    chk(rd_val, 16'hf73f);
    mode_chk(CCPOS_MODE_SINGLE, 2'h0, 0, 1'b1);
    mode_chk(CCPOS_MODE_SINGLE, 2'h2, 0, 1'b0);
    mode_chk(CCPOS_MODE_PUSHPULL, 2'h0, 1, 1'b1);
    mode_chk(CCPOS_MODE_PUSHPULL, 2'h1, 1, 1'b0);
    mode_chk(CCPOS_MODE_HALFBR, 2'h1, 1, 1'b1);
    mode_chk(CCPOS_MODE_BDC_FWD, 2'h0, 0, 1'b1);
    mode_chk(CCPOS_MODE_BDC_REV, 2'h0, 2, 1'b1);
    mode_chk(CCPOS_MODE_SCAN, 2'h0, 2, 1'b1);
    mode_chk(CCPOS_MODE_RSV7, 2'h0, 0, 1'b0);
    mode_chk(CCPOS_MODE_RSV3, 2'h0, 1, 1'b0);
    mode_chk(CCPOS_MODE_HALFBR, 2'h0, 0, 1'b1);
    @(posedge clk);
    trig_en <= 1'b1;
    wr(CCPOS_ADDR_CTRL, 16'h8000);
    repeat (3) @(posedge clk);
    #1;
    chk({10'h000, oe_b}, 16'h003f);
    rd(CCPOS_ADDR_STAT);
    chk(rd_val, 16'h0003);
    @(posedge clk);
    trigger_in <= 1'b1;
    @(posedge clk);
    trigger_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, level[0]}, 16'h0001);
    rd(CCPOS_ADDR_STAT);
    chk(rd_val, 16'h0000);
    mode_chk(CCPOS_MODE_SINGLE, 2'h0, 0, 1'b1);
    @(posedge clk);
    trig_en <= 1'b0;
    pwm_primary <= 1'b0;
    for (int i = 0; i < 8; i++)
      shot(3'(i));
    give_verdict();
  end
endmodule : tb_ccpos_top
`default_nettype wire
